// ==== rtl/sld_cfg.svh ====
// Constants of the serial-in latched sink driver.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH

// ----------------------------------------
// Structure
// ----------------------------------------
`define SLD_STAGES 8
`define SLD_FIFO_WIDTH 1
`define SLD_FIFO_DEPTH 16
`define SLD_SYNC_WIDTH 4

// ----------------------------------------
// Sync vector bit positions
// ----------------------------------------
`define SLD_SY_DATA 0
`define SLD_SY_SCLK 1
`define SLD_SY_LOAD 2
`define SLD_SY_OEN 3

// ----------------------------------------
// Reset values and pacing
// ----------------------------------------
`define SLD_STAGE_RST 8'h00
`define SLD_LATCH_RST 8'h00
`define SLD_POP_DIV 2'h2

`endif

// ==== rtl/sld_pkg.sv ====
// Types of the serial-in latched sink driver.
// Assumes sld_cfg.svh is in the include path.
`default_nettype none
`include "sld_cfg.svh"

package sld_pkg;
    typedef logic [`SLD_STAGES-1:0] sld_stage_t;
    typedef logic [`SLD_FIFO_WIDTH-1:0] sld_word_t;
    typedef enum logic [1:0] {
        SLD_POP_WAIT = 2'h1,
        SLD_POP_GO = 2'h2
    } sld_pop_t;
endpackage : sld_pkg

`default_nettype wire

// ==== rtl/sld_stream_if.sv ====
// Valid/ready stream of captured serial bits.
// Assumes both ends share one clock.
`default_nettype none
`include "sld_cfg.svh"

interface sld_stream_if;
    logic valid;
    logic ready;
    sld_pkg::sld_word_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sld_stream_if

`default_nettype wire

// ==== rtl/sld_sync.sv ====
// Two-flop synchroniser for pin inputs.
// Assumes inputs asynchronous to clk.
`default_nettype none

module sld_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins in, synchronised out
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule : sld_sync

`default_nettype wire

// ==== rtl/sld_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; push and pop ends are interface modports.
`default_nettype none

module sld_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Stream ends
    sld_stream_if.snk push,
    sld_stream_if.src pop
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign push.ready = !full;
    assign pop.valid = !empty;
    assign pop.data = mem[rd_q[AW-1:0]];
    assign do_push = push.valid && !full;
    assign do_pop = pop.ready && !empty;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_q[AW-1:0]] <= push.data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + (AW+1)'(1);
            end
            if (do_pop) begin
                rd_q <= rd_q + (AW+1)'(1);
            end
        end
    end
endmodule : sld_fifo

`default_nettype wire

// ==== rtl/sld_top.sv ====
// Serial-in latched sink driver: shift register, latches, output gating.
// Assumes all pin inputs are asynchronous to clk; resetn stands for power-on.
//
// What this block does
// - Rising shift clock captures data into stage one.
// - Further rising edges shift stages toward cascade.
// - Last stage drives the cascade output.
// - Strobe high loads each latch from stage.
// - Strobe high transparent; strobe low holds latches.
// - Output enable high turns all sinks off.
// - Output enable never touches register or latches.
// - Output enable low: sinks follow their latches.
// - Power-on clears every stage and latch.
`default_nettype none
`include "sld_cfg.svh"

module sld_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Host pins
    input wire logic serial_data_pin,
    input wire logic shift_clock_pin,
    input wire logic latch_load_pin,
    input wire logic out_enable_n,
    // Sink drives, bit 0 is sink_drive_first, bit 7 sink_drive_last
    output logic [`SLD_STAGES-1:0] sink_drive_q,
    // Cascade and flow status
    output logic cascade_out_q,
    output logic capture_ready_q
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic sld_pkg::sld_stage_t gate_sinks(input sld_pkg::sld_stage_t lat, input logic off);
        gate_sinks = off ? sld_pkg::sld_stage_t'(`SLD_LATCH_RST) : lat;
    endfunction : gate_sinks

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [`SLD_SYNC_WIDTH-1:0] pins_s;
    logic data_s;
    logic sclk_s;
    logic load_s;
    logic oen_s;

    sld_sync #(.W(`SLD_SYNC_WIDTH)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin_in({out_enable_n, latch_load_pin, shift_clock_pin, serial_data_pin}),
        .sync_out(pins_s)
    );

    assign data_s = pins_s[`SLD_SY_DATA];
    assign sclk_s = pins_s[`SLD_SY_SCLK];
    assign load_s = pins_s[`SLD_SY_LOAD];
    assign oen_s = pins_s[`SLD_SY_OEN];

    // ----------------------------------------
    // Edge capture into the FIFO
    // ----------------------------------------
    logic sclk_prev_q;
    logic sclk_rise;
    sld_stream_if cap_if ();
    sld_stream_if shf_if ();

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_prev_q;
    assign cap_if.valid = sclk_rise;
    assign cap_if.data = data_s;

    sld_fifo #(.WIDTH(`SLD_FIFO_WIDTH), .DEPTH(`SLD_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .push(cap_if.snk),
        .pop(shf_if.src)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            capture_ready_q <= 1'b0;
        end else begin
            capture_ready_q <= cap_if.ready;
        end
    end

    // ----------------------------------------
    // Shift pacing
    // ----------------------------------------
    sld_pkg::sld_pop_t pop_st_q;
    logic [1:0] div_q;
    logic pop_fire;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 2'h0;
        end else if (div_q == `SLD_POP_DIV - 2'h1) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pop_st_q <= sld_pkg::SLD_POP_WAIT;
        end else begin
            case (pop_st_q)
                sld_pkg::SLD_POP_WAIT: begin
                    if (div_q == `SLD_POP_DIV - 2'h2) begin
                        pop_st_q <= sld_pkg::SLD_POP_GO;
                    end
                end
                sld_pkg::SLD_POP_GO: begin
                    pop_st_q <= sld_pkg::SLD_POP_WAIT;
                end
                default: begin
                    pop_st_q <= sld_pkg::SLD_POP_WAIT;
                end
            endcase
        end
    end

    assign shf_if.ready = (pop_st_q == sld_pkg::SLD_POP_GO);
    assign pop_fire = shf_if.ready && shf_if.valid;

    // ----------------------------------------
    // Shift register
    // ----------------------------------------
    sld_pkg::sld_stage_t stage_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage_q <= `SLD_STAGE_RST;
        end else if (pop_fire) begin
            stage_q <= {stage_q[`SLD_STAGES-2:0], shf_if.data[0]};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cascade_out_q <= 1'b0;
        end else begin
            cascade_out_q <= stage_q[`SLD_STAGES-1];
        end
    end

    // ----------------------------------------
    // Latches
    // ----------------------------------------
    sld_pkg::sld_stage_t latch_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_q <= `SLD_LATCH_RST;
        end else if (load_s) begin
            latch_q <= stage_q;
        end
    end

    // ----------------------------------------
    // Sink outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sink_drive_q <= `SLD_LATCH_RST;
        end else begin
            sink_drive_q <= gate_sinks(latch_q, oen_s);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_first_stage_load: assert property (@(posedge clk) disable iff (!resetn)
        pop_fire |=> stage_q[0] == $past(shf_if.data[0]))
        else $error("Stage one did not take the captured bit.");

    a_stage_shift: assert property (@(posedge clk) disable iff (!resetn)
        pop_fire |=> stage_q[7:1] == $past(stage_q[6:0]))
        else $error("Stages did not shift toward cascade.");

    a_stage_hold: assert property (@(posedge clk) disable iff (!resetn)
        !pop_fire |=> $stable(stage_q))
        else $error("Shift register changed without a shift.");

    a_cascade_follow: assert property (@(posedge clk) disable iff (!resetn)
        pop_fire ##1 1'b1 |=> cascade_out_q == $past(stage_q[7]))
        else $error("Cascade output does not show last stage.");

    a_latch_follow: assert property (@(posedge clk) disable iff (!resetn)
        load_s |=> latch_q == $past(stage_q))
        else $error("Latch did not load while strobe high.");

    a_latch_hold: assert property (@(posedge clk) disable iff (!resetn)
        !load_s |=> $stable(latch_q))
        else $error("Latch changed while strobe low.");

    a_sink_off: assert property (@(posedge clk) disable iff (!resetn)
        oen_s |=> sink_drive_q == 8'h00)
        else $error("Sink on while outputs disabled.");

    a_sink_follow: assert property (@(posedge clk) disable iff (!resetn)
        !oen_s |=> sink_drive_q == $past(latch_q))
        else $error("Sink does not follow its latch.");

    a_oe_no_touch: assert property (@(posedge clk) disable iff (!resetn)
        (!load_s && !pop_fire && $changed(oen_s)) |=> $stable(latch_q) && $stable(stage_q))
        else $error("Output enable disturbed stored data.");

    a_reset_clear: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> stage_q == 8'h00 && latch_q == 8'h00)
        else $error("Stages or latches not clear after reset.");

    a_pop_spacing: assert property (@(posedge clk) disable iff (!resetn)
        pop_fire |=> !pop_fire)
        else $error("Two shifts in consecutive cycles.");

    a_pop_onehot: assert property (@(posedge clk) disable iff (!resetn)
        $onehot(pop_st_q))
        else $error("Shift pacing state is not one-hot.");

    a_pop_on_slot: assert property (@(posedge clk) disable iff (!resetn)
        pop_fire |-> div_q == `SLD_POP_DIV - 2'h1)
        else $error("Shift fired outside its pacing slot.");

    a_pop_go_once: assert property (@(posedge clk) disable iff (!resetn)
        pop_st_q == sld_pkg::SLD_POP_GO |=> pop_st_q == sld_pkg::SLD_POP_WAIT)
        else $error("Shift slot lasted more than one cycle.");

    a_div_range: assert property (@(posedge clk) disable iff (!resetn)
        div_q < `SLD_POP_DIV)
        else $error("Pacing divider out of range.");

    a_div_step: assert property (@(posedge clk) disable iff (!resetn)
        div_q == 2'h0 |=> div_q == 2'h1)
        else $error("Pacing divider did not advance.");

    a_edge_single: assert property (@(posedge clk) disable iff (!resetn)
        sclk_rise |=> !sclk_rise)
        else $error("One shift clock edge seen twice.");

    a_capture_pushed: assert property (@(posedge clk) disable iff (!resetn)
        sclk_rise && cap_if.ready |=> shf_if.valid)
        else $error("Captured bit was not queued.");

    a_cascade_track: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> cascade_out_q == $past(stage_q[`SLD_STAGES-1]))
        else $error("Cascade output lags the last stage.");

    a_cascade_hold: assert property (@(posedge clk) disable iff (!resetn)
        !pop_fire |-> ##2 $stable(cascade_out_q))
        else $error("Cascade output changed without a shift.");

    a_stage_source: assert property (@(posedge clk) disable iff (!resetn)
        $changed(stage_q) |-> $past(pop_fire))
        else $error("Stages changed without a shift clock edge.");

    a_stage_keep_load: assert property (@(posedge clk) disable iff (!resetn)
        load_s && !pop_fire |=> $stable(stage_q))
        else $error("Strobe disturbed the shift register.");

    a_oen_no_stage: assert property (@(posedge clk) disable iff (!resetn)
        $changed(oen_s) && !pop_fire |=> $stable(stage_q))
        else $error("Output enable disturbed the shift register.");

    a_latch_source: assert property (@(posedge clk) disable iff (!resetn)
        $changed(latch_q) |-> $past(load_s))
        else $error("Latches changed while strobe low.");

    a_load_sink_off: assert property (@(posedge clk) disable iff (!resetn)
        oen_s && load_s |=> sink_drive_q == 8'h00)
        else $error("Latch load turned a disabled sink on.");

    a_sink_needs_latch: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> (sink_drive_q & ~$past(latch_q)) == 8'h00)
        else $error("Sink on while its latch is low.");

    a_sink_on_high: assert property (@(posedge clk) disable iff (!resetn)
        !oen_s |=> (~sink_drive_q & $past(latch_q)) == 8'h00)
        else $error("Enabled sink off while its latch is high.");

    a_sink_reset_clear: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> sink_drive_q == 8'h00 && !cascade_out_q)
        else $error("Sinks or cascade not clear after reset.");

    a_ready_after_reset: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |=> capture_ready_q)
        else $error("Capture not ready after reset.");
endmodule : sld_top

`default_nettype wire

// ==== sim/sld_host.sv ====
// Host controller model that drives the serial pins of the sink driver.
// Assumes clk is the driver's clock; pins change only at its falling edge.
`default_nettype none

module sld_host (
    // Clock
    input wire logic clk,
    // Pins to the driver
    output logic serial_data_pin,
    output logic shift_clock_pin,
    output logic latch_load_pin,
    output logic out_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Power-on levels
    // ----------------------------------------
    initial begin
        serial_data_pin = 1'b0;
        shift_clock_pin = 1'b0;
        latch_load_pin = 1'b0;
        out_enable_n = 1'b0;
    end

    // ----------------------------------------
    // Pin sequences
    // ----------------------------------------
    // Data is set two cycles ahead of the rising shift clock, then inverted once its hold runs out.
    task automatic send_bit(input logic b);
        serial_data_pin = b;
        repeat (2) @(negedge clk);
        shift_clock_pin = 1'b1;
        repeat (2) @(negedge clk);
        shift_clock_pin = 1'b0;
        serial_data_pin = ~b;
        repeat (2) @(negedge clk);
    endtask : send_bit

    // Sends the top bit first, so it ends in the last stage.
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            send_bit(v[i]);
        end
        repeat (8) @(negedge clk);
    endtask : send_byte

    task automatic strobe_pulse();
        latch_load_pin = 1'b1;
        repeat (3) @(negedge clk);
        latch_load_pin = 1'b0;
        repeat (4) @(negedge clk);
    endtask : strobe_pulse

    task automatic set_load(input logic l);
        latch_load_pin = l;
        repeat (4) @(negedge clk);
    endtask : set_load

    task automatic set_enable(input logic n);
        out_enable_n = n;
        repeat (4) @(negedge clk);
    endtask : set_enable

    task automatic all_low();
        serial_data_pin = 1'b0;
        shift_clock_pin = 1'b0;
        latch_load_pin = 1'b0;
        out_enable_n = 1'b0;
    endtask : all_low
endmodule : sld_host

`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking testbench of the serial-in latched sink driver.
// Assumes the rtl files and sld_host are compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    wire logic serial_data_pin;
    wire logic shift_clock_pin;
    wire logic latch_load_pin;
    wire logic out_enable_n;
    wire logic [7:0] sink_drive_q;
    wire logic cascade_out_q;
    wire logic capture_ready_q;
    sld_pkg::sld_stage_t shadow = 8'h00;
    int n_fail = 0;
    int checked = 0;

    always #20 clk = ~clk;

    sld_host host (.clk(clk), .serial_data_pin(serial_data_pin), .shift_clock_pin(shift_clock_pin),
        .latch_load_pin(latch_load_pin), .out_enable_n(out_enable_n));

    sld_top DUT (.clk(clk), .resetn(resetn), .serial_data_pin(serial_data_pin),
        .shift_clock_pin(shift_clock_pin), .latch_load_pin(latch_load_pin), .out_enable_n(out_enable_n),
        .sink_drive_q(sink_drive_q), .cascade_out_q(cascade_out_q), .capture_ready_q(capture_ready_q));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Power-on with all pins low clears stages and latches, also in mid-run.
    task automatic test_reset();
        host.all_low();
        resetn = 1'b0;
        repeat (10) @(negedge clk);
        check("sinks in reset", sink_drive_q, 8'h00);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        shadow = 8'h00;
        check("sinks after reset", sink_drive_q, 8'h00);
        check("cascade after reset", {7'h00, cascade_out_q}, 8'h00);
        check("ready after reset", {7'h00, capture_ready_q}, 8'h01);
        host.strobe_pulse();
        check("sinks strobe after reset", sink_drive_q, 8'h00);
        $display("test reset done");
    endtask : test_reset

    // Each bit walks through eight stages to the cascade while latches hold.
    task automatic test_shift();
        logic [15:0] pat;
        pat = 16'ha53c;
        for (int i = 15; i >= 0; i--) begin
            host.send_bit(pat[i]);
            shadow = {shadow[6:0], pat[i]};
            repeat (4) @(negedge clk);
            check("cascade", {7'h00, cascade_out_q}, {7'h00, shadow[7]});
            check("sinks held", sink_drive_q, 8'h00);
        end
        $display("test shift done");
    endtask : test_shift

    // Strobe copies stages to latches; a new byte without strobe leaves them alone.
    task automatic test_latch();
        host.strobe_pulse();
        check("sinks after strobe", sink_drive_q, 8'h3c);
        host.send_byte(8'h0f);
        check("sinks held low strobe", sink_drive_q, 8'h3c);
        host.strobe_pulse();
        check("sinks second strobe", sink_drive_q, 8'h0f);
        $display("test latch done");
    endtask : test_latch

    // Disabled outputs stay off while register and latches keep working.
    task automatic test_enable();
        host.set_enable(1'b1);
        check("sinks disabled", sink_drive_q, 8'h00);
        host.send_byte(8'hc3);
        host.strobe_pulse();
        check("sinks disabled load", sink_drive_q, 8'h00);
        check("cascade disabled", {7'h00, cascade_out_q}, 8'h01);
        host.set_enable(1'b0);
        check("sinks enabled", sink_drive_q, 8'hc3);
        $display("test enable done");
    endtask : test_enable

    // Strobe held high makes latches follow the register; released strobe holds them against a new byte.
    task automatic test_transparent();
        host.set_enable(1'b1);
        host.set_load(1'b1);
        host.send_byte(8'h5a);
        check("sinks off transparent", sink_drive_q, 8'h00);
        host.set_enable(1'b0);
        check("sinks transparent", sink_drive_q, 8'h5a);
        host.set_load(1'b0);
        host.set_enable(1'b1);
        host.send_byte(8'h81);
        host.set_enable(1'b0);
        check("sinks after release", sink_drive_q, 8'h5a);
        $display("test transparent done");
    endtask : test_transparent

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        test_reset();
        test_shift();
        test_latch();
        test_enable();
        test_transparent();
        test_reset();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
endmodule : testbench

`default_nettype wire
